// [verilog/gpio_grp_pkg.sv]
// Constants and carrier types for the pin configuration group 2.1-3.2.
// Assumes a single 50 MHz clock and an 8-bit register port.
package gpio_grp_pkg;

    localparam int NPIN = 9;

    // Pin slots in the configuration array.
    localparam int P21 = 0;
    localparam int P22 = 1;
    localparam int P24 = 2;
    localparam int P25 = 3;
    localparam int P26 = 4;
    localparam int P27 = 5;
    localparam int P30 = 6;
    localparam int P31 = 7;
    localparam int P32 = 8;

    // Register offsets.
    localparam logic [7:0] CFG_OFS [NPIN] = '{
        8'h2c, 8'h2d, 8'h2f, 8'h30, 8'h31, 8'h32, 8'h33, 8'h34, 8'h35
    };
    localparam logic [7:0] OFS_RSVD = 8'h2e;
    localparam logic [7:0] OFS_DATA_LO = 8'h40;
    localparam logic [7:0] OFS_DATA_HI = 8'h41;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h42;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h43;

    // Writable bits; reserved bits are never stored and read as zero.
    localparam logic [7:0] CFG_WMASK [NPIN] = '{
        8'h8f, 8'h8f, 8'h83, 8'h87, 8'h87, 8'h87, 8'h87, 8'h87, 8'h87
    };

    // Field positions inside a configuration byte.
    localparam int BIT_DIR = 0;
    localparam int BIT_POL = 1;
    localparam int BIT_ALT = 2;
    localparam int BIT_SEL_HI = 3;
    localparam int BIT_OD = 7;

    // Two-bit alternate select codes.
    localparam logic [1:0] SEL_GPIO = 2'h0;
    localparam logic [1:0] SEL_KBC = 2'h1;
    localparam logic [1:0] SEL_EDGE = 2'h2;
    localparam logic [1:0] SEL_FLOPPY = 2'h3;

    // Reset values.
    localparam logic [7:0] CFG_RESET = 8'h01;
    localparam logic [7:0] FAN_MAIN_RESET = 8'h00;
    localparam logic [8:0] DATA_RESET = 9'h000;

    // Interrupt status and mask layout.
    localparam int IRQ_W = 2;
    localparam int IRQ_EDGE0 = 0;
    localparam int IRQ_EDGE1 = 1;
    localparam logic [1:0] IRQ_RESET = 2'h0;

    // Values that internal peripherals want driven onto the pins.
    typedef struct packed {
        logic floppy_drive_select_1;
        logic floppy_motor_select_1;
        logic kbc_port_pin_1_6;
        logic kbc_port_pin_1_2;
        logic music_serial_output;
        logic system_mgmt_interrupt_out;
        logic fan_output_2;
    } alt_drive_s;

    // Pin levels delivered to internal peripherals.
    typedef struct packed {
        logic kbc_port_pin_1_6;
        logic kbc_port_pin_1_2;
        logic music_serial_input;
        logic tachometer_input_2;
        logic tachometer_input_1;
    } alt_sense_s;

endpackage

// [verilog/gpio_grp.sv]
// Pin configuration and pad drive for pins 2.1-3.2, either-edge interrupts for pins 2.1 and 2.2.
// Assumes pad inputs and peripheral signals are synchronous to SYS_CLK_I.
`timescale 1ns/1ps
`default_nettype none

module gpio_grp (
    // Clock and resets
    input wire logic SYS_CLK_I,
    input wire logic SYS_RST_I,
    input wire logic MAIN_RST_I,
    // Register port
    input wire logic [7:0] REG_ADDR_I,
    input wire logic [7:0] REG_WDATA_I,
    input wire logic REG_WR_I,
    input wire logic REG_RD_I,
    output logic [7:0] REG_RDATA_O,
    // Pads
    input wire logic [8:0] PAD_DATA_I,
    output logic [8:0] PAD_DATA_O,
    output logic [8:0] PAD_OE_O,
    // Alternate-function peripherals
    input wire gpio_grp_pkg::alt_drive_s ALT_DRIVE_I,
    output gpio_grp_pkg::alt_sense_s ALT_SENSE_O,
    // Interrupt
    output logic IRQ_O
);

    // Returns the configuration slot for an address, or NPIN if none.
    function automatic logic [3:0] cfg_index(input logic [7:0] a);
        logic [3:0] r;
        r = 4'(gpio_grp_pkg::NPIN);
        for (int i = 0; i < gpio_grp_pkg::NPIN; i++) begin
            if (a == gpio_grp_pkg::CFG_OFS[i]) begin
                r = 4'(i);
            end
        end
        return r;
    endfunction

    // Two-bit alternate select of a configuration byte.
    function automatic logic [1:0] sel_of(input logic [7:0] c);
        return c[gpio_grp_pkg::BIT_SEL_HI:gpio_grp_pkg::BIT_ALT];
    endfunction

    logic [7:0] cfg_q [gpio_grp_pkg::NPIN];
    logic [8:0] data_out_q;
    logic [8:0] in_prev_q;
    logic [gpio_grp_pkg::IRQ_W-1:0] stat_q;
    logic [gpio_grp_pkg::IRQ_W-1:0] mask_q;
    logic [gpio_grp_pkg::IRQ_W-1:0] edge_evt;
    logic [gpio_grp_pkg::IRQ_W-1:0] stat_clr;
    logic [7:0] rdata_d;
    logic [8:0] pol;
    logic [8:0] in_val;
    logic [8:0] drv_val;
    logic [8:0] drv_en;
    logic [8:0] pad_val;
    logic [3:0] wr_idx;
    logic [3:0] rd_idx;
    logic [1:0] sel21;
    logic [1:0] sel22;

    assign wr_idx = cfg_index(REG_ADDR_I);
    assign rd_idx = wr_idx;
    assign sel21 = sel_of(cfg_q[gpio_grp_pkg::P21]);
    assign sel22 = sel_of(cfg_q[gpio_grp_pkg::P22]);

    // Configuration registers, one per pin.
    for (genvar g = 0; g < gpio_grp_pkg::NPIN; g++) begin : g_cfg
        always_ff @(posedge SYS_CLK_I) begin
            if (SYS_RST_I) begin
                cfg_q[g] <= gpio_grp_pkg::CFG_RESET;
            end else if (g == gpio_grp_pkg::P32 && MAIN_RST_I) begin
                cfg_q[g] <= gpio_grp_pkg::FAN_MAIN_RESET;
            end else if (REG_WR_I && wr_idx == 4'(g)) begin
                // Reserved bits are dropped here, so they read as zero.
                cfg_q[g] <= REG_WDATA_I &
                    gpio_grp_pkg::CFG_WMASK[g];
            end
        end
        assign pol[g] = cfg_q[g][gpio_grp_pkg::BIT_POL];
    end

    // Pin levels as seen by the register logic.
    assign in_val = PAD_DATA_I ^ pol;

    // GPIO output latch, split over two byte registers.
    always_ff @(posedge SYS_CLK_I) begin
        if (SYS_RST_I) begin
            data_out_q <= gpio_grp_pkg::DATA_RESET;
        end else if (REG_WR_I) begin
            if (REG_ADDR_I == gpio_grp_pkg::OFS_DATA_LO) begin
                data_out_q[7:0] <= REG_WDATA_I;
            end else if (REG_ADDR_I == gpio_grp_pkg::OFS_DATA_HI) begin
                data_out_q[8] <= REG_WDATA_I[0];
            end
        end
    end

    // Drive selection. Alternate outputs own the pin regardless of the
    // direction bit, since the peripheral cannot work otherwise.
    always_comb begin
        for (int i = 0; i < gpio_grp_pkg::NPIN; i++) begin
            drv_val[i] = data_out_q[i];
            drv_en[i] = ~cfg_q[i][gpio_grp_pkg::BIT_DIR];
        end
        case (sel21)
            gpio_grp_pkg::SEL_FLOPPY: begin
                drv_val[gpio_grp_pkg::P21] = ALT_DRIVE_I.floppy_drive_select_1;
                drv_en[gpio_grp_pkg::P21] = 1'b1;
            end
            gpio_grp_pkg::SEL_EDGE: begin
                drv_en[gpio_grp_pkg::P21] = 1'b0;
            end
            gpio_grp_pkg::SEL_KBC: begin
                drv_val[gpio_grp_pkg::P21] = ALT_DRIVE_I.kbc_port_pin_1_6;
                drv_en[gpio_grp_pkg::P21] = 1'b1;
            end
            default: begin
            end
        endcase
        case (sel22)
            gpio_grp_pkg::SEL_FLOPPY: begin
                drv_val[gpio_grp_pkg::P22] = ALT_DRIVE_I.floppy_motor_select_1;
                drv_en[gpio_grp_pkg::P22] = 1'b1;
            end
            gpio_grp_pkg::SEL_EDGE: begin
                drv_en[gpio_grp_pkg::P22] = 1'b0;
            end
            gpio_grp_pkg::SEL_KBC: begin
                drv_val[gpio_grp_pkg::P22] = ALT_DRIVE_I.kbc_port_pin_1_2;
                drv_en[gpio_grp_pkg::P22] = 1'b1;
            end
            default: begin
            end
        endcase
        // Pin 2.4 keeps the plain GPIO drive set above.
        if (cfg_q[gpio_grp_pkg::P25][gpio_grp_pkg::BIT_ALT]) begin
            drv_en[gpio_grp_pkg::P25] = 1'b0;
        end
        if (cfg_q[gpio_grp_pkg::P26][gpio_grp_pkg::BIT_ALT]) begin
            drv_val[gpio_grp_pkg::P26] = ALT_DRIVE_I.music_serial_output;
            drv_en[gpio_grp_pkg::P26] = 1'b1;
        end
        if (cfg_q[gpio_grp_pkg::P27][gpio_grp_pkg::BIT_ALT]) begin
            drv_val[gpio_grp_pkg::P27] =
                ALT_DRIVE_I.system_mgmt_interrupt_out;
            drv_en[gpio_grp_pkg::P27] = 1'b1;
        end
        if (cfg_q[gpio_grp_pkg::P30][gpio_grp_pkg::BIT_ALT]) begin
            drv_en[gpio_grp_pkg::P30] = 1'b0;
        end
        if (cfg_q[gpio_grp_pkg::P31][gpio_grp_pkg::BIT_ALT]) begin
            drv_en[gpio_grp_pkg::P31] = 1'b0;
        end
        if (cfg_q[gpio_grp_pkg::P32][gpio_grp_pkg::BIT_ALT]) begin
            drv_val[gpio_grp_pkg::P32] = ALT_DRIVE_I.fan_output_2;
            drv_en[gpio_grp_pkg::P32] = 1'b1;
        end
    end

    assign pad_val = drv_val ^ pol;

    // Pad outputs are registered. An open-drain pin only pulls low and
    // releases the line for a high level.
    for (genvar g = 0; g < gpio_grp_pkg::NPIN; g++) begin : g_pad
        always_ff @(posedge SYS_CLK_I) begin
            if (SYS_RST_I) begin
                PAD_DATA_O[g] <= 1'b0;
                PAD_OE_O[g] <= 1'b0;
            end else begin
                PAD_DATA_O[g] <= pad_val[g];
                PAD_OE_O[g] <= drv_en[g] &
                    (~cfg_q[g][gpio_grp_pkg::BIT_OD] | ~pad_val[g]);
            end
        end
    end

    // Pin levels handed to the peripherals; idle high when not selected.
    always_ff @(posedge SYS_CLK_I) begin
        if (SYS_RST_I) begin
            ALT_SENSE_O <= '1;
        end else begin
            ALT_SENSE_O.kbc_port_pin_1_6 <=
                (sel21 == gpio_grp_pkg::SEL_KBC) ?
                in_val[gpio_grp_pkg::P21] : 1'b1;
            ALT_SENSE_O.kbc_port_pin_1_2 <=
                (sel22 == gpio_grp_pkg::SEL_KBC) ?
                in_val[gpio_grp_pkg::P22] : 1'b1;
            ALT_SENSE_O.music_serial_input <=
                cfg_q[gpio_grp_pkg::P25][gpio_grp_pkg::BIT_ALT] ?
                in_val[gpio_grp_pkg::P25] : 1'b1;
            ALT_SENSE_O.tachometer_input_2 <=
                cfg_q[gpio_grp_pkg::P30][gpio_grp_pkg::BIT_ALT] ?
                in_val[gpio_grp_pkg::P30] : 1'b1;
            ALT_SENSE_O.tachometer_input_1 <=
                cfg_q[gpio_grp_pkg::P31][gpio_grp_pkg::BIT_ALT] ?
                in_val[gpio_grp_pkg::P31] : 1'b1;
        end
    end

    // Previous pin levels for edge detection.
    always_ff @(posedge SYS_CLK_I) begin
        if (SYS_RST_I) begin
            // Idle pads read high through their pull-ups, so start there.
            in_prev_q <= '1;
        end else begin
            in_prev_q <= in_val;
        end
    end

    // Either edge counts. The first cycle after selecting the mode may
    // report a spurious edge if the pin differs from its old level.
    assign edge_evt[gpio_grp_pkg::IRQ_EDGE0] =
        (sel21 == gpio_grp_pkg::SEL_EDGE) &
        (in_val[gpio_grp_pkg::P21] ^ in_prev_q[gpio_grp_pkg::P21]);
    assign edge_evt[gpio_grp_pkg::IRQ_EDGE1] =
        (sel22 == gpio_grp_pkg::SEL_EDGE) &
        (in_val[gpio_grp_pkg::P22] ^ in_prev_q[gpio_grp_pkg::P22]);

    assign stat_clr = (REG_WR_I &&
        REG_ADDR_I == gpio_grp_pkg::OFS_IRQ_STAT) ?
        REG_WDATA_I[gpio_grp_pkg::IRQ_W-1:0] : '0;

    // Sticky status: a new edge wins over a clear in the same cycle.
    always_ff @(posedge SYS_CLK_I) begin
        if (SYS_RST_I) begin
            stat_q <= gpio_grp_pkg::IRQ_RESET;
        end else begin
            stat_q <= (stat_q & ~stat_clr) | edge_evt;
        end
    end

    always_ff @(posedge SYS_CLK_I) begin
        if (SYS_RST_I) begin
            mask_q <= gpio_grp_pkg::IRQ_RESET;
        end else if (REG_WR_I &&
            REG_ADDR_I == gpio_grp_pkg::OFS_IRQ_MASK) begin
            mask_q <= REG_WDATA_I[gpio_grp_pkg::IRQ_W-1:0];
        end
    end

    always_ff @(posedge SYS_CLK_I) begin
        if (SYS_RST_I) begin
            IRQ_O <= 1'b0;
        end else begin
            IRQ_O <= |(stat_q & mask_q);
        end
    end

    // Read multiplexer; unmapped offsets and the hole at 2E give zero.
    always_comb begin
        rdata_d = 8'h00;
        if (rd_idx < 4'(gpio_grp_pkg::NPIN)) begin
            rdata_d = cfg_q[rd_idx];
        end else begin
            case (REG_ADDR_I)
                gpio_grp_pkg::OFS_RSVD: rdata_d = 8'h00;
                gpio_grp_pkg::OFS_DATA_LO: rdata_d = in_val[7:0];
                gpio_grp_pkg::OFS_DATA_HI: rdata_d = {7'h00, in_val[8]};
                gpio_grp_pkg::OFS_IRQ_STAT: rdata_d = {6'h00, stat_q};
                gpio_grp_pkg::OFS_IRQ_MASK: rdata_d = {6'h00, mask_q};
                default: rdata_d = 8'h00;
            endcase
        end
    end

    // Read data stands only in the cycle after the strobe.
    always_ff @(posedge SYS_CLK_I) begin
        if (SYS_RST_I) begin
            REG_RDATA_O <= 8'h00;
        end else if (REG_RD_I) begin
            REG_RDATA_O <= rdata_d;
        end else begin
            REG_RDATA_O <= 8'h00;
        end
    end

endmodule // gpio_grp

`default_nettype wire

// [tb/gpio_pin_model.sv]
// External pads: resolves each pad from the block drive and the bench drive.
// Assumes the bench drives only pads that the block leaves undriven.
`timescale 1ns/1ps
`default_nettype none
module gpio_pin_model (
    // Block side
    input wire logic [8:0] drive_i,
    input wire logic [8:0] oe_i,
    // Bench side
    input wire logic [8:0] ext_en_i,
    input wire logic [8:0] ext_val_i,
    // Resolved pad levels
    output logic [8:0] level_o
);
    // A pad nobody drives reads high, as its pull-up would make it.
    assign level_o = (oe_i & drive_i) | (~oe_i & ~ext_en_i)
        | (~oe_i & ext_en_i & ext_val_i);
endmodule // gpio_pin_model
`default_nettype wire

// [tb/gpio_grp_monitor.sv]
// Port checker for the pin group, bound into gpio_grp.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module gpio_grp_monitor (
    // Clock and resets
    input wire logic SYS_CLK_I,
    input wire logic SYS_RST_I,
    input wire logic MAIN_RST_I,
    // Register port
    input wire logic [7:0] REG_ADDR_I,
    input wire logic [7:0] REG_WDATA_I,
    input wire logic REG_WR_I,
    input wire logic REG_RD_I,
    input wire logic [7:0] REG_RDATA_O,
    // Pads, peripherals and interrupt
    input wire logic [8:0] PAD_DATA_I,
    input wire logic [8:0] PAD_DATA_O,
    input wire logic [8:0] PAD_OE_O,
    input wire gpio_grp_pkg::alt_drive_s ALT_DRIVE_I,
    input wire gpio_grp_pkg::alt_sense_s ALT_SENSE_O,
    input wire logic IRQ_O
);
    logic [7:0] cfg_q [9];
    logic [3:0] sel;
    default clocking cb @(posedge SYS_CLK_I); endclocking
    default disable iff (SYS_RST_I);
    always_comb begin
        sel = 4'hf;
        for (int i = 0; i < 9; i++) begin
            if (REG_ADDR_I == gpio_grp_pkg::CFG_OFS[i]) begin
                sel = 4'(i);
            end
        end
    end
    // A shadow of the bytes keeps the pad checks outside the design.
    always_ff @(posedge SYS_CLK_I) begin
        for (int i = 0; i < 9; i++) begin
            if (SYS_RST_I) begin
                cfg_q[i] <= gpio_grp_pkg::CFG_RESET;
            end else if (i == 8 && MAIN_RST_I) begin
                // The main reset beats a write in the same cycle.
                cfg_q[i] <= gpio_grp_pkg::FAN_MAIN_RESET;
            end else if (REG_WR_I && sel == 4'(i)) begin
                cfg_q[i] <= REG_WDATA_I & gpio_grp_pkg::CFG_WMASK[i];
            end
        end
    end
    sequence s_quiet;
        !REG_WR_I ##1 !REG_WR_I;
    endsequence
    property p_rsvd;
        REG_RD_I && REG_ADDR_I == 8'h2e |=> REG_RDATA_O == 8'h00; endproperty
    a_rsvd: assert property (p_rsvd)
        else $error("reserved slot read nonzero");
    property p_gpio;
        PAD_OE_O[2] == (!$past(cfg_q[2][0])
            && (!$past(cfg_q[2][7]) || !PAD_DATA_O[2])); endproperty
    a_gpio: assert property (p_gpio)
        else $error("plain pad enable wrong");
    property p_floppy;
        $past(cfg_q[0][3:2] == 2'h3 && !cfg_q[0][7]) |-> PAD_OE_O[0] &&
        PAD_DATA_O[0] == $past(ALT_DRIVE_I.floppy_drive_select_1
            ^ cfg_q[0][1]); endproperty
    a_floppy: assert property (p_floppy)
        else $error("drive select pad wrong");
    property p_edge;
        $past(cfg_q[0][3:2] == 2'h2) |-> !PAD_OE_O[0]; endproperty
    a_edge: assert property (p_edge)
        else $error("edge input pad driven");
    property p_tach;
        $past(cfg_q[6][2]) |-> !PAD_OE_O[6] && ALT_SENSE_O.tachometer_input_2
            == $past(PAD_DATA_I[6] ^ cfg_q[6][1]); endproperty
    a_tach: assert property (p_tach)
        else $error("tachometer sense wrong");
    property p_mgmt;
        $past(cfg_q[5][2] && !cfg_q[5][7]) |-> PAD_OE_O[5] && PAD_DATA_O[5]
        == $past(ALT_DRIVE_I.system_mgmt_interrupt_out ^ cfg_q[5][1]);
    endproperty
    a_mgmt: assert property (p_mgmt)
        else $error("management pad wrong");
    property p_irq;
        s_quiet ##1 $rose(IRQ_O) |->
            $past(PAD_DATA_I[1:0], 2) != $past(PAD_DATA_I[1:0], 3); endproperty
    a_irq: assert property (p_irq)
        else $error("interrupt without pad edge");
    property p_fan;
        MAIN_RST_I && !REG_WR_I ##1 !REG_WR_I |=> PAD_OE_O[8]; endproperty
    a_fan: assert property (p_fan)
        else $error("fan pad not driven after main reset");
endmodule // gpio_grp_monitor
bind gpio_grp gpio_grp_monitor u_mon (
    .SYS_CLK_I(SYS_CLK_I), .SYS_RST_I(SYS_RST_I), .MAIN_RST_I(MAIN_RST_I),
    .REG_ADDR_I(REG_ADDR_I), .REG_WDATA_I(REG_WDATA_I), .REG_WR_I(REG_WR_I),
    .REG_RD_I(REG_RD_I), .REG_RDATA_O(REG_RDATA_O), .IRQ_O(IRQ_O),
    .PAD_DATA_I(PAD_DATA_I), .PAD_DATA_O(PAD_DATA_O), .PAD_OE_O(PAD_OE_O),
    .ALT_DRIVE_I(ALT_DRIVE_I), .ALT_SENSE_O(ALT_SENSE_O));
`default_nettype wire

// [tb/gpio_grp_test.sv]
// Self-checking bench for the pin group: registers, pads, interrupts.
// Assumes gpio_pin_model on the pads and the bound checker.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin tests_run++; if ((a) !== (e)) begin failures++; \
    $display("unexpected %s exp %h got %h", n, e, a); end end
module gpio_grp_test;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic main_rst = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] rdata;
    logic [8:0] pad_in, pad_out, pad_oe;
    logic [8:0] ext_en = 9'h000;
    logic [8:0] ext_val = 9'h000;
    gpio_grp_pkg::alt_drive_s alt_drv = '0;
    gpio_grp_pkg::alt_sense_s alt_sns;
    logic irq;
    int failures = 0;
    int tests_run = 0;
    always #10 clk = ~clk;
    gpio_grp DUT (
        .SYS_CLK_I(clk), .SYS_RST_I(rst), .MAIN_RST_I(main_rst),
        .REG_ADDR_I(addr), .REG_WDATA_I(wdata), .REG_WR_I(wr),
        .REG_RD_I(rd), .REG_RDATA_O(rdata), .PAD_DATA_I(pad_in),
        .PAD_DATA_O(pad_out), .PAD_OE_O(pad_oe), .ALT_DRIVE_I(alt_drv),
        .ALT_SENSE_O(alt_sns), .IRQ_O(irq));
    gpio_pin_model u_pins (.drive_i(pad_out), .oe_i(pad_oe),
        .ext_en_i(ext_en), .ext_val_i(ext_val), .level_o(pad_in));
    task automatic stop_test();
        if (failures == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic pins(input logic [8:0] en, input logic [8:0] v);
        @(posedge clk);
        ext_en <= en;
        ext_val <= v;
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        rd_reg(a, d);
        `CHK("register", e, d)
    endtask
    task automatic wait_irq(input logic e);
        #1;
        for (int n = 0; n < 8 && irq !== e; n++) settle(1);
        `CHK("interrupt", e, irq)
        if (irq !== e) stop_test();
    endtask
    task automatic t_regs();
        for (int i = 0; i < 9; i++) begin
            rd_chk(gpio_grp_pkg::CFG_OFS[i], 8'h01);
        end
        `CHK("enables", 9'h000, pad_oe)
        wr_reg(8'h2e, 8'hff);
        rd_chk(8'h2e, 8'h00);
        rd_chk(8'h7f, 8'h00);
        for (int i = 0; i < 9; i++) begin
            wr_reg(gpio_grp_pkg::CFG_OFS[i], 8'hff);
            rd_chk(gpio_grp_pkg::CFG_OFS[i],
                i < 2 ? 8'h8f : i == 2 ? 8'h83 : 8'h87);
        end
    endtask
    task automatic t_drive();
        logic [7:0] cfgs [5] = '{8'h00, 8'h02, 8'h80, 8'h80, 8'h01};
        logic [7:0] lats [5] = '{8'h04, 8'h04, 8'h04, 8'h00, 8'h04};
        logic [4:0] oes = 5'b01011;
        logic [4:0] dos = 5'b00001;
        logic [7:0] d;
        for (int i = 0; i < 5; i++) begin
            wr_reg(8'h40, lats[i]);
            wr_reg(8'h2f, cfgs[i]);
            settle(2);
            `CHK("enable", oes[i], pad_oe[2])
            if (oes[i]) `CHK("level", dos[i], pad_out[2])
        end
        pins(9'h004, 9'h000);
        for (int p = 0; p < 2; p++) begin
            wr_reg(8'h2f, 8'h01 | 8'(p << 1));
            rd_reg(8'h40, d);
            `CHK("pin", 1'(p), d[2])
        end
    endtask
    task automatic t_alt();
        logic [6:0] pats [2] = '{7'h55, 7'h2a};
        logic [6:0] p;
        for (int i = 0; i < 9; i++) begin
            if (i != 2) begin
                wr_reg(gpio_grp_pkg::CFG_OFS[i], i < 2 ? 8'h0c : 8'h04);
            end
        end
        for (int k = 0; k < 2; k++) begin
            p = pats[k];
            @(posedge clk);
            alt_drv <= gpio_grp_pkg::alt_drive_s'(p);
            pins(9'h0c8, p[0] ? 9'h0c8 : 9'h000);
            settle(3);
            `CHK("enables", 9'h133, pad_oe)
            `CHK("levels", {p[0], 2'b00, p[1], p[2], 2'b00, p[5], p[6]},
                pad_out & 9'h133)
            `CHK("sense", {3{p[0]}}, alt_sns[2:0])
        end
        wr_reg(8'h2c, 8'h04);
        wr_reg(8'h2d, 8'h04);
        settle(3);
        `CHK("kbc pads", {p[3], p[4]}, pad_out[1:0])
        `CHK("kbc sense", {p[4], p[3]}, alt_sns[4:3])
    endtask
    task automatic t_irq();
        pins(9'h003, 9'h003);
        wr_reg(8'h2c, 8'h09);
        wr_reg(8'h2d, 8'h09);
        wr_reg(8'h43, 8'h01);
        wr_reg(8'h42, 8'h03);
        rd_chk(8'h42, 8'h00);
        pins(9'h003, 9'h001);
        settle(3);
        `CHK("masked", 1'b0, irq)
        rd_chk(8'h42, 8'h02);
        pins(9'h003, 9'h000);
        wait_irq(1'b1);
        wr_reg(8'h42, 8'h01);
        wait_irq(1'b0);
        rd_chk(8'h42, 8'h02);
        wr_reg(8'h43, 8'h03);
        wait_irq(1'b1);
        wr_reg(8'h42, 8'h03);
        wait_irq(1'b0);
        pins(9'h003, 9'h001);
        wait_irq(1'b1);
    endtask
    task automatic t_main();
        wr_reg(8'h35, 8'h81);
        @(posedge clk);
        main_rst <= 1'b1;
        @(posedge clk);
        main_rst <= 1'b0;
        rd_chk(8'h35, 8'h00);
        rd_chk(8'h34, 8'h04);
        `CHK("fan enable", 1'b1, pad_oe[8])
        wr_reg(8'h41, 8'h01);
        settle(2);
        `CHK("fan level", 1'b1, pad_out[8])
        rd_chk(8'h41, 8'h01);
    endtask
    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        t_regs();
        t_drive();
        t_alt();
        t_irq();
        t_main();
        stop_test();
    end
endmodule // gpio_grp_test
`default_nettype wire
